// File: src_regs.vh
// Constants for the security region command block
`ifndef SRC_REGS_VH
`define SRC_REGS_VH

// ----------------------------------------
// Opcodes
// ----------------------------------------
`define SRC_OP_ERASE 8'h44
`define SRC_OP_PROG  8'h42
`define SRC_OP_READ  8'h48

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define SRC_REG_STATUS 8'h00
`define SRC_REG_CTRL   8'h04
`define SRC_REG_LOCK   8'h08

// ----------------------------------------
// Field positions, lock reset value and erased byte value
// ----------------------------------------
`define SRC_ST_BUSY   0
`define SRC_ST_WEL    1
`define SRC_ST_PUDONE 2
`define SRC_ST_LOCK   4
`define SRC_CTRL_WEL  0
`define SRC_LOCK_RST  3'h0
`define SRC_ERASED    8'hff

// ----------------------------------------
// Timing
// ----------------------------------------
`define SRC_CLK_MHZ  200
`define SRC_PUW_US   1000
`define SRC_ERASE_US 100
`define SRC_PROG_US  20
`define SRC_PUW_CYC   (`SRC_PUW_US * `SRC_CLK_MHZ)
`define SRC_ERASE_CYC (`SRC_ERASE_US * `SRC_CLK_MHZ)
`define SRC_PROG_CYC  (`SRC_PROG_US * `SRC_CLK_MHZ)

`endif

// File: src_mem.v
// Byte store for the three security regions, registered read port
`timescale 1ns/1ps
`include "src_regs.vh"
module src_mem (
  sys_clk,
  we,
  wr_erase,
  waddr,
  wdata,
  raddr,
  rdata
);
  input  wire       sys_clk;
  input  wire       we;
  input  wire       wr_erase;
  input  wire [9:0] waddr;
  input  wire [7:0] wdata;
  input  wire [9:0] raddr;
  output reg  [7:0] rdata;

  reg [7:0] mem [0:1023];

  // Program only clears bits, as a flash cell does
  always @(posedge sys_clk) begin
    if (we) begin
      mem[waddr] <= wr_erase ? `SRC_ERASED : (mem[waddr] & wdata);
    end
    rdata <= mem[raddr];
  end
endmodule

// File: src_top.v
// Security region erase, program and read over the serial link
`timescale 1ns/1ps
`include "src_regs.vh"
module src_top #(
  parameter [31:0] PUW_CYC   = `SRC_PUW_CYC,
  parameter [31:0] ERASE_CYC = `SRC_ERASE_CYC,
  parameter [31:0] PROG_CYC  = `SRC_PROG_CYC
) (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg  [31:0] hrdata,
  output reg         hresp,
  input  wire        sel_n,
  input  wire        sclk,
  input  wire        sdi,
  output reg         sdo,
  output reg         sdo_oe
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [5:0] ST_CMD  = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_DUMY = 6'h04;
  localparam [5:0] ST_RDAT = 6'h08;
  localparam [5:0] ST_PDAT = 6'h10;
  localparam [5:0] ST_SKIP = 6'h20;

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Region number 1..3, or 0 for an address outside every region
  function [1:0] fn_region;
    input [23:0] a;
    begin
      if (a[23:16] == 8'h00 && a[11:8] == 4'h0 && a[15:14] == 2'h0)
        fn_region = a[13:12];
      else
        fn_region = 2'h0;
    end
  endfunction

  function fn_locked;
    input [2:0] locks;
    input [1:0] region;
    begin
      case (region)
        2'h1:    fn_locked = locks[0];
        2'h2:    fn_locked = locks[1];
        2'h3:    fn_locked = locks[2];
        default: fn_locked = 1'b1;
      endcase
    end
  endfunction

  // ----------------------------------------
  // Reset release and pin synchronisers
  // ----------------------------------------
  reg       rst_s1_ff;
  reg       rst_sync_n;
  reg [2:0] pin_s1_ff;
  reg [2:0] pin_s2_ff;
  reg [2:0] pin_s3_ff;

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_s1_ff  <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_s1_ff  <= 1'b1;
      rst_sync_n <= rst_s1_ff;
    end
  end

  // Bit 2 select, bit 1 clock, bit 0 data
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_s1_ff <= 3'h4;
      pin_s2_ff <= 3'h4;
      pin_s3_ff <= 3'h4;
    end else begin
      pin_s1_ff <= {sel_n, sclk, sdi};
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  wire sel_hi    = pin_s2_ff[2];
  wire sel_rise  = pin_s2_ff[2] & ~pin_s3_ff[2];
  wire clk_rise  = ~sel_hi & pin_s2_ff[1] & ~pin_s3_ff[1];
  wire clk_fall  = ~sel_hi & ~pin_s2_ff[1] & pin_s3_ff[1];
  wire din       = pin_s2_ff[0];

  // ----------------------------------------
  // Shared state
  // ----------------------------------------
  reg  [5:0]  state_ff;
  reg  [7:0]  op_ff;
  reg  [22:0] sh_ff;
  reg  [4:0]  bitcnt_ff;
  reg  [1:0]  region_ff;
  reg  [7:0]  off_ff;
  reg         armed_ff;
  reg         prog_any_ff;
  reg  [7:0]  rdsh_ff;
  reg         prog_we_ff;
  reg  [9:0]  prog_addr_ff;
  reg  [7:0]  prog_data_ff;
  reg         busy_ff;
  reg  [31:0] busy_cnt_ff;
  reg         ers_run_ff;
  reg  [7:0]  ers_idx_ff;
  reg  [1:0]  ers_region_ff;
  reg         write_enable_latch;
  reg  [2:0]  region_lock_bits;
  reg  [31:0] pu_cnt_ff;
  reg         pu_done_ff;
  reg         dp_wr_ff;
  reg  [7:0]  dp_addr_ff;
  wire [7:0]  mem_rdata;
  wire [23:0] addr_in = {sh_ff, din};
  wire [7:0]  byte_in = {sh_ff[6:0], din};

  // Gate shared by every write-type command
  wire write_ok = write_enable_latch & pu_done_ff & ~busy_ff
                  & ~fn_locked(region_lock_bits, region_ff);

  // ----------------------------------------
  // Serial command engine
  // ----------------------------------------
  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_ff     <= ST_CMD;
      op_ff        <= 8'h00;
      sh_ff        <= 23'h0;
      bitcnt_ff    <= 5'h00;
      region_ff    <= 2'h0;
      off_ff       <= 8'h00;
      armed_ff     <= 1'b0;
      prog_any_ff  <= 1'b0;
      rdsh_ff      <= 8'h00;
      prog_we_ff   <= 1'b0;
      prog_addr_ff <= 10'h000;
      prog_data_ff <= 8'h00;
      sdo          <= 1'b0;
      sdo_oe       <= 1'b0;
    end else begin
      prog_we_ff <= 1'b0;
      if (sel_hi) begin
        state_ff  <= ST_CMD;
        bitcnt_ff <= 5'h00;
        armed_ff  <= 1'b0;
        sdo_oe    <= 1'b0;
      end else if (clk_rise) begin
        sh_ff     <= addr_in[22:0];
        bitcnt_ff <= bitcnt_ff + 5'h01;
        armed_ff  <= 1'b0;
        case (state_ff)
          ST_CMD: begin
            if (bitcnt_ff == 5'd7) begin
              op_ff     <= byte_in;
              bitcnt_ff <= 5'h00;
              if (byte_in == `SRC_OP_ERASE || byte_in == `SRC_OP_PROG ||
                  byte_in == `SRC_OP_READ)
                state_ff <= ST_ADDR;
              else
                state_ff <= ST_SKIP;
            end
          end
          ST_ADDR: begin
            if (bitcnt_ff == 5'd23) begin
              bitcnt_ff   <= 5'h00;
              region_ff   <= fn_region(addr_in);
              off_ff      <= addr_in[7:0];
              prog_any_ff <= 1'b0;
              armed_ff    <= (op_ff == `SRC_OP_ERASE);
              if (op_ff == `SRC_OP_READ)
                state_ff <= (busy_ff || fn_region(addr_in) == 2'h0) ?
                            ST_SKIP : ST_DUMY;
              else if (op_ff == `SRC_OP_PROG)
                state_ff <= ST_PDAT;
              else
                state_ff <= ST_SKIP;
            end
          end
          ST_DUMY, ST_RDAT: begin
            // Read port had eight clocks to settle on the new offset
            if (bitcnt_ff == 5'd7) begin
              bitcnt_ff <= 5'h00;
              rdsh_ff   <= mem_rdata;
              off_ff    <= off_ff + 8'h01;
              sdo_oe    <= 1'b1;
              state_ff  <= ST_RDAT;
            end
          end
          ST_PDAT: begin
            if (bitcnt_ff == 5'd7) begin
              bitcnt_ff <= 5'h00;
              armed_ff  <= 1'b1;
              off_ff    <= off_ff + 8'h01;
              if (write_ok) begin
                prog_we_ff   <= 1'b1;
                prog_addr_ff <= {region_ff, off_ff};
                prog_data_ff <= byte_in;
                prog_any_ff  <= 1'b1;
              end
            end
          end
          default: begin
            bitcnt_ff <= 5'h00;
          end
        endcase
      end else if (clk_fall && state_ff == ST_RDAT) begin
        sdo     <= rdsh_ff[7];
        rdsh_ff <= {rdsh_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Region store
  // ----------------------------------------
  src_mem u_mem (
    .sys_clk  (sys_clk),
    .we       (prog_we_ff | ers_run_ff),
    .wr_erase (ers_run_ff),
    .waddr    (ers_run_ff ? {ers_region_ff, ers_idx_ff} : prog_addr_ff),
    .wdata    (prog_data_ff),
    .raddr    ({region_ff, off_ff}),
    .rdata    (mem_rdata)
  );

  // ----------------------------------------
  // Busy timer, write enable, locks, power-up
  // ----------------------------------------
  wire erase_go = sel_rise & armed_ff & (op_ff == `SRC_OP_ERASE)
                  & (region_ff != 2'h0) & write_ok;
  wire prog_go  = sel_rise & armed_ff & (op_ff == `SRC_OP_PROG) & prog_any_ff;
  wire wr_stb   = dp_wr_ff;

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      busy_ff            <= 1'b0;
      busy_cnt_ff        <= 32'h0;
      ers_run_ff         <= 1'b0;
      ers_idx_ff         <= 8'h00;
      ers_region_ff      <= 2'h0;
      write_enable_latch <= 1'b0;
      region_lock_bits   <= `SRC_LOCK_RST;
      pu_cnt_ff          <= 32'h0;
      pu_done_ff         <= 1'b0;
    end else begin
      if (!pu_done_ff) begin
        if (pu_cnt_ff >= PUW_CYC - 32'h1)
          pu_done_ff <= 1'b1;
        else
          pu_cnt_ff <= pu_cnt_ff + 32'h1;
      end
      if (erase_go) begin
        busy_ff            <= 1'b1;
        busy_cnt_ff        <= ERASE_CYC - 32'h1;
        ers_run_ff         <= 1'b1;
        ers_idx_ff         <= 8'h00;
        ers_region_ff      <= region_ff;
        write_enable_latch <= 1'b0;
      end else if (prog_go) begin
        busy_ff            <= 1'b1;
        busy_cnt_ff        <= PROG_CYC - 32'h1;
        write_enable_latch <= 1'b0;
      end else if (busy_ff) begin
        if (busy_cnt_ff == 32'h0)
          busy_ff <= 1'b0;
        else
          busy_cnt_ff <= busy_cnt_ff - 32'h1;
      end
      // Sweep writes FFh over the region early in the busy window
      if (ers_run_ff) begin
        ers_idx_ff <= ers_idx_ff + 8'h01;
        if (ers_idx_ff == 8'hff)
          ers_run_ff <= 1'b0;
      end
      // Software set wins over the hardware clear in the same cycle
      if (wr_stb && dp_addr_ff == `SRC_REG_CTRL && hwdata[`SRC_CTRL_WEL])
        write_enable_latch <= 1'b1;
      // Locks are one-way: a written 1 stays until the next reset
      if (wr_stb && dp_addr_ff == `SRC_REG_LOCK)
        region_lock_bits <= region_lock_bits | hwdata[2:0];
    end
  end

  // ----------------------------------------
  // AHB-Lite slave, zero wait states
  // ----------------------------------------
  wire       aphase = hsel & htrans[1] & hready;
  reg [31:0] rd_val;

  always @* begin
    rd_val = 32'h0;
    case (haddr[7:0])
      `SRC_REG_STATUS: begin
        rd_val[`SRC_ST_BUSY]   = busy_ff;
        rd_val[`SRC_ST_WEL]    = write_enable_latch;
        rd_val[`SRC_ST_PUDONE] = pu_done_ff;
        rd_val[`SRC_ST_LOCK +: 3] = region_lock_bits;
      end
      `SRC_REG_CTRL: rd_val[`SRC_CTRL_WEL] = write_enable_latch;
      `SRC_REG_LOCK: rd_val[2:0] = region_lock_bits;
      default:       rd_val = 32'h0;
    endcase
  end

  always @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      hrdata     <= 32'h0;
      dp_wr_ff   <= 1'b0;
      dp_addr_ff <= 8'h00;
    end else begin
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
      dp_wr_ff   <= aphase & hwrite;
      dp_addr_ff <= (aphase && haddr[31:8] == 24'h0) ? haddr[7:0] : 8'hfc;
      if (aphase && !hwrite)
        hrdata <= (haddr[31:8] == 24'h0) ? rd_val : 32'h0;
    end
  end
endmodule

// File: src_props.sv
// Port assertions for the security region command block
`timescale 1ns/1ps
`include "src_regs.vh"
module src_props #(
  parameter [31:0] PUW_CYC = 32'd50
) (
  input wire        sys_clk,
  input wire        rst_n,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [2:0]  hsize,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire        hreadyout,
  input wire [31:0] hrdata,
  input wire        hresp,
  input wire        sel_n,
  input wire        sclk,
  input wire        sdi,
  input wire        sdo,
  input wire        sdo_oe
);
  default clocking dc @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // --------------------
  // Lock shadow, age
  // --------------------
  wire       go = hsel && htrans[1] && hready;
  wire       st_rd = go && !hwrite && haddr[7:0] == `SRC_REG_STATUS;
  reg [31:0] age_ff;
  reg [2:0]  lk_ff;
  reg [2:0]  lk_old_ff;
  reg        lk_wr_ff;
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      age_ff <= 32'h0;
      lk_ff <= 3'h0;
      lk_old_ff <= 3'h0;
      lk_wr_ff <= 1'b0;
    end else begin
      if (age_ff < PUW_CYC + 32'h10)
        age_ff <= age_ff + 32'h1;
      if (lk_wr_ff)
        lk_ff <= lk_ff | hwdata[2:0];
      // Read loaded in a write's data phase still shows the old value
      lk_old_ff <= lk_ff;
      lk_wr_ff <= go && hwrite && haddr[7:0] == `SRC_REG_LOCK;
    end
  end
  ready_high_a: assert property (hreadyout && !hresp)
    else $error("bus not ready");
  rdata_hold_a: assert property (!(go && !hwrite) |=> $stable(hrdata))
    else $error("hrdata moved");
  lock_keep_a: assert property (st_rd |=> hrdata[6:4] == lk_old_ff)
    else $error("lock bits wrong");
  pud_early_a: assert property (st_rd && age_ff < PUW_CYC |=> !hrdata[2])
    else $error("power-up done early");
  pud_late_a: assert property (st_rd && age_ff > PUW_CYC + 32'h8 |=> hrdata[2])
    else $error("power-up done late");
  out_edge_a: assert property (sdo_oe && $past(sdo_oe) && $changed(sdo) |-> !$past(sclk))
    else $error("sdo moved off a falling edge");
  oe_start_a: assert property ($rose(sdo_oe) |-> !$past(sel_n, 3))
    else $error("sdo driven outside a frame");
  oe_stop_a: assert property (sel_n [*5] |-> !sdo_oe)
    else $error("sdo still driven");
  cover property ($rose(sdo_oe));
  cover property (st_rd);
  cover property (lk_wr_ff);
endmodule

// File: src_host.sv
// Host serial controller model for the security region link
`timescale 1ns/1ps
module src_host #(
  parameter integer HALF = 24
) (
  output reg  sel_n = 1'b1,
  output reg  sclk = 1'b0,
  output reg  sdi = 1'b0,
  input  wire sdo
);
  task open_f;
    begin
      sel_n <= 1'b0;
      #HALF;
    end
  endtask
  // Data moves with the clock low; the clock stands still between frames
  task put(input [7:0] v, input integer n);
    integer k;
    begin
      for (k = 7; k > 7 - n; k = k - 1) begin
        sdi <= v[k];
        #HALF sclk <= 1'b1;
        #HALF sclk <= 1'b0;
      end
    end
  endtask
  task get(output [7:0] v);
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        sdi <= ~sdi;
        #HALF sclk <= 1'b1;
        v = {v[6:0], sdo};
        #HALF sclk <= 1'b0;
      end
    end
  endtask
  task close_f;
    begin
      #HALF sel_n <= 1'b1;
      #(2 * HALF) sdi <= ~sdi;
    end
  endtask
endmodule

// File: src_top_test.sv
// Self-checking bench for the security region command block
`timescale 1ns/1ps
`include "src_regs.vh"
module src_top_test;
  localparam [31:0] PUW = 32'd2000;
  localparam [31:0] ERS = 32'd1000;
  localparam [31:0] PRG = 32'd20;
  reg         sys_clk = 1'b0;
  reg         rst_n = 1'b0;
  reg         hsel = 1'b0;
  reg  [31:0] haddr = 32'h0;
  reg  [1:0]  htrans = 2'h0;
  reg         hwrite = 1'b0;
  reg  [31:0] hwdata = 32'h0;
  reg  [2:0]  hsize = 3'h0;
  reg  [31:0] rd;
  reg  [7:0]  b;
  reg  [7:0]  off;
  reg  [7:0]  mem [0:1023];
  wire        hready, hresp, sel_n, sclk, sdi, sdo, sdo_oe;
  wire [31:0] hrdata;
  integer     fail_count = 0;
  integer     compares = 0;
  integer     oe_cnt = 0;
  integer     g, i, n;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) if (sdo_oe === 1'b1) oe_cnt <= oe_cnt + 1;
  src_top #(.PUW_CYC(PUW), .ERASE_CYC(ERS), .PROG_CYC(PRG)) i_src_top (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hrdata(hrdata), .hresp(hresp), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
    .sdo_oe(sdo_oe));
  // Undriven line shows the inverse of its last bit, so stale data cannot pass
  wire        sdo_pin = sdo_oe ? sdo : ~sdo;
  src_host i_src_host (.sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo_pin));
  task check(input [31:0] got, input [31:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task close_out;
    begin
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task ahb(input [31:0] a, input w, input [31:0] d);
    begin
      @(posedge sys_clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hsize <= 3'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge sys_clk);
      while (hready !== 1'b1) @(posedge sys_clk);
      rd = hrdata;
    end
  endtask
  // Middle address byte that selects region r
  function [7:0] addr_mid(input [1:0] r);
    begin
      addr_mid = {2'b00, r, 4'h0};
    end
  endfunction
  // Expected read byte from the bench's own copy of the regions
  function [31:0] exp_byte(input [1:0] r, input [7:0] o);
    begin
      exp_byte = {24'h0, mem[{r, o}]};
    end
  endfunction
  task cmd(input [7:0] op, input [1:0] r, input [7:0] o);
    begin
      if (op != `SRC_OP_READ)
        ahb(`SRC_REG_CTRL, 1'b1, 32'h1);
      i_src_host.open_f;
      i_src_host.put(op, 8);
      i_src_host.put(8'h00, 8);
      i_src_host.put(addr_mid(r), 8);
      i_src_host.put(o, 8);
    end
  endtask
  task rd_chk(input [1:0] r, input [7:0] o, input integer cnt);
    integer k;
    begin
      cmd(`SRC_OP_READ, r, o);
      i_src_host.put(8'h00, 8);
      for (k = 0; k < cnt; k = k + 1) begin
        i_src_host.get(b);
        check({24'h0, b}, exp_byte(r, o + k[7:0]));
      end
      i_src_host.close_f;
    end
  endtask
  // cyc 0: expect idle, 1: expect busy only, else also time the busy span
  task idle(input integer cyc);
    integer k;
    time    t0;
    begin
      t0 = $time;
      ahb(`SRC_REG_STATUS, 1'b0, 32'h0);
      check(rd[`SRC_ST_BUSY], cyc != 0);
      for (k = 0; k < 4000 && rd[0] !== 1'b0; k = k + 1)
        ahb(`SRC_REG_STATUS, 1'b0, 32'h0);
      check(rd[`SRC_ST_BUSY], 1'b0);
      k = ($time - t0) / 5;
      if (cyc > 1)
        check(k >= cyc - 12 && k <= cyc + 8, 1'b1);
    end
  endtask
  initial begin
    n = $urandom(69260);
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    ahb(32'h0c, 1'b0, 32'h0);
    check(rd, 32'h0);
    cmd(`SRC_OP_ERASE, 2'd1, 8'h00);
    i_src_host.close_f;
    idle(0);
    check(rd[`SRC_ST_PUDONE], 1'b0);
    repeat (PUW) @(posedge sys_clk);
    idle(0);
    check(rd[`SRC_ST_PUDONE], 1'b1);
    $display("test power-up done");
    for (g = 1; g < 4; g = g + 1) begin
      off = $urandom;
      cmd(`SRC_OP_ERASE, g[1:0], off);
      i_src_host.close_f;
      idle(ERS);
      for (i = 0; i < 256; i = i + 1)
        mem[g * 256 + i] = `SRC_ERASED;
      n = 1 + $urandom % 4;
      cmd(`SRC_OP_PROG, g[1:0], off);
      for (i = 0; i < n; i = i + 1) begin
        b = $urandom;
        i_src_host.put(b, 8);
        mem[g * 256 + (off + i) % 256] = b;
      end
      i_src_host.close_f;
      idle(PRG);
      rd_chk(g[1:0], off - 8'h01, n + 2);
    end
    $display("test erase program read done");
    i_src_host.open_f;
    i_src_host.put(`SRC_OP_PROG, 8);
    i_src_host.put(8'h00, 8);
    i_src_host.put(8'h20, 8);
    i_src_host.put(off, 8);
    i_src_host.put(8'h00, 8);
    i_src_host.close_f;
    idle(0);
    // Erase with the write enable latch still clear
    i_src_host.open_f;
    i_src_host.put(`SRC_OP_ERASE, 8);
    i_src_host.put(8'h00, 8);
    i_src_host.put(addr_mid(2'd2), 8);
    i_src_host.put(8'h00, 8);
    i_src_host.close_f;
    idle(0);
    cmd(`SRC_OP_ERASE, 2'd3, 8'h00);
    i_src_host.put(8'h00, 1);
    i_src_host.close_f;
    idle(0);
    // Opcode one bit away from erase must do nothing
    cmd(8'h45, 2'd3, 8'h00);
    i_src_host.close_f;
    idle(0);
    // Region field of zero selects nothing, so no data is driven
    i = oe_cnt;
    cmd(`SRC_OP_READ, 2'd0, 8'h00);
    i_src_host.put(8'h00, 8);
    i_src_host.get(b);
    i_src_host.close_f;
    check(oe_cnt - i, 32'h0);
    rd_chk(2'd2, off, 1);
    rd_chk(2'd3, 8'hfe, 4);
    $display("test refusals done");
    ahb(`SRC_REG_LOCK, 1'b1, 32'h4);
    ahb(`SRC_REG_STATUS, 1'b0, 32'h0);
    check(rd[`SRC_ST_LOCK +: 3], 3'h4);
    cmd(`SRC_OP_ERASE, 2'd3, 8'h00);
    i_src_host.close_f;
    idle(0);
    cmd(`SRC_OP_PROG, 2'd3, off);
    i_src_host.put(8'h00, 8);
    i_src_host.close_f;
    idle(0);
    rd_chk(2'd3, off, n);
    $display("test lock done");
    cmd(`SRC_OP_ERASE, 2'd1, 8'h00);
    i_src_host.close_f;
    i = oe_cnt;
    cmd(`SRC_OP_READ, 2'd1, 8'h00);
    i_src_host.put(8'h00, 8);
    i_src_host.get(b);
    i_src_host.close_f;
    check(oe_cnt - i, 32'h0);
    idle(1);
    for (i = 256; i < 512; i = i + 1)
      mem[i] = `SRC_ERASED;
    rd_chk(2'd1, 8'hff, 2);
    $display("test read while busy done");
    close_out;
  end
  initial begin
    #400000;
    fail_count = fail_count + 1;
    close_out;
  end
endmodule
bind src_top src_props #(.PUW_CYC(PUW_CYC)) i_src_props (
  .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .sel_n(sel_n), .sclk(sclk), .sdi(sdi), .sdo(sdo),
  .sdo_oe(sdo_oe));
